// ### hdl/wave_ctrl.sv
// Control, configuration and output stage of the four-output complementary waveform unit
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Unit starts halted; software programs both override levels before enabling.
// - Halt flag must clear to run; hardware clears it with auto-restart.
// - Enable is bit 7 of main control; 1 enables, reset 0.
// - Load request copies dead-band counts after falling then rising input edge; self-clears.
// - Load request is taken only while already enabled, never with enable.
// - Three-bit mode: steering, full-bridge forward or reverse, half-bridge, push-pull.
// - Polarity register bit 5 reads the synchronised selected input level.
// - Polarity bits 3..0 invert outputs D..A when set; reset 0.
// - Clock select bit 0: 0 system clock, 1 fast internal oscillator.
// - Four-bit data source field picks one of fourteen inputs; 1110,1111 reserved.
// - Unimplemented register bits read zero and ignore writes.
// - Dead-band counter counts module clock edges from zero to count; zero bypasses.
// - After halt clears, outputs resume at the next rising input edge.
// - Override levels: 11 one, 10 zero, 01 float, 00 inactive level from the polarity bit, with no dead band.
module wave_ctrl
  import wave_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     fast_osc_tick,
  // Wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [5:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  // Sources and halt inputs
  input  wire logic [source_count-1:0]  source_in,
  input  wire logic [4:0]               halt_in_n,
  // Outputs to switch drivers, enable low while driving
  output wave_ctrl_pkg::outputs_type    drive
);
  import wave_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] main_q, main_d, pol_q, pol_d, clk_q, clk_d, dat_q, dat_d;
  logic [7:0] str_q, str_d, hf_q, hf_d, hs_q, hs_d, dbr_q, dbr_d, dbf_q, dbf_d;
  logic [5:0] act_r_q, act_r_d, act_f_q, act_f_d;
  logic       ack_q, ack_d, sync1_q, sync2_q, prev_q, seen_fall_q, seen_fall_d;
  logic       run_q, run_d, out_q, out_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] rdat_q, rdat_d;
  logic       wr, rise, fall, sel_in, tick, halt_now, en;

  assign en   = main_q[enable_bit];
  assign tick = clk_q[0] ? fast_osc_tick : 1'b1;
  assign sel_in = (dat_q[3:0] < 4'(source_count)) ? source_in[dat_q[3:0]] : 1'b0;
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  // Writes land on the edge at which the master samples ack high
  assign wr   = cyc_i & stb_i & we_i & sel_i[0] & ack_q;
  assign halt_now = |(hs_q[4:0] & ~halt_in_n);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus answer
  always_comb begin
    main_d = main_q; pol_d = pol_q; clk_d = clk_q; dat_d = dat_q; str_d = str_q;
    hf_d = hf_q; hs_d = hs_q; dbr_d = dbr_q; dbf_d = dbf_q;
    act_r_d = act_r_q; act_f_d = act_f_q; seen_fall_d = seen_fall_q;
    ack_d = cyc_i & stb_i & ~ack_q;
    rdat_d = 32'h0;
    if (wr) begin
      case ({2'b00, adr_i[5:2]})
        6'(off_control_main >> 2): begin
          main_d = dat_i[7:0] & mask_control_main;
          if (!en || !main_d[enable_bit]) main_d[load_bit] = 1'b0;
          else if (!dat_i[load_bit]) main_d[load_bit] = main_q[load_bit];
        end
        6'(off_polarity >> 2):      pol_d = dat_i[7:0] & mask_polarity;
        6'(off_clock_select >> 2):  clk_d = dat_i[7:0] & mask_clock_select;
        6'(off_data_select >> 2):   dat_d = dat_i[7:0] & mask_data_select;
        6'(off_steering >> 2):      str_d = dat_i[7:0];
        6'(off_halt_first >> 2):    hf_d = dat_i[7:0] & mask_halt_first;
        6'(off_halt_sources >> 2):  hs_d = dat_i[7:0] & mask_halt_sources;
        6'(off_rise_count >> 2):    dbr_d = dat_i[7:0] & mask_deadband;
        6'(off_fall_count >> 2):    dbf_d = dat_i[7:0] & mask_deadband;
        default: ;
      endcase
    end
    if (!main_d[enable_bit]) begin
      act_r_d = dbr_d[5:0];
      act_f_d = dbf_d[5:0];
    end
    // Buffer load: falling edge, then the following rising edge
    if (en && main_q[load_bit]) begin
      if (fall) seen_fall_d = 1'b1;
      if (rise && seen_fall_q) begin
        act_r_d = dbr_q[5:0];
        act_f_d = dbf_q[5:0];
        main_d[load_bit] = 1'b0;
        seen_fall_d = 1'b0;
      end
    end else seen_fall_d = 1'b0;
    // Halt flag: hardware set wins over software clear
    if (halt_now) hf_d[halt_flag_bit] = 1'b1;
    else if (hf_q[restart_bit] && en) hf_d[halt_flag_bit] = 1'b0;
    if (cyc_i && stb_i && !we_i) begin
      case ({2'b00, adr_i[5:2]})
        6'(off_control_main >> 2):  rdat_d[7:0] = main_q;
        6'(off_polarity >> 2):      rdat_d[7:0] = pol_q | ({7'h0, sync2_q} << input_level_bit);
        6'(off_clock_select >> 2):  rdat_d[7:0] = clk_q;
        6'(off_data_select >> 2):   rdat_d[7:0] = dat_q;
        6'(off_steering >> 2):      rdat_d[7:0] = str_q;
        6'(off_halt_first >> 2):    rdat_d[7:0] = hf_q;
        6'(off_halt_sources >> 2):  rdat_d[7:0] = hs_q;
        6'(off_rise_count >> 2):    rdat_d[7:0] = dbr_q;
        6'(off_fall_count >> 2):    rdat_d[7:0] = dbf_q;
        default:                    rdat_d = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform core: run state, edge following and dead band
  always_comb begin
    run_d = run_q;
    out_d = out_q;
    cnt_d = cnt_q;
    if (!en || hf_q[halt_flag_bit]) begin
      run_d = 1'b0;
      cnt_d = 6'h0;
      out_d = 1'b0;
    end else if (!run_q) begin
      if (rise) begin
        run_d = 1'b1;
        out_d = 1'b0;
        cnt_d = 6'h0;
      end
    end else begin
      if (rise || fall) cnt_d = 6'h0;
      else if (tick && cnt_q != 6'h3f) cnt_d = cnt_q + 6'h1;
      out_d = sync2_q;
    end
  end

  logic        a_on, b_on, dead_r, dead_f;
  logic [3:0]  raw;
  assign dead_r = (act_r_q != 6'h0) && (cnt_q < act_r_q);
  assign dead_f = (act_f_q != 6'h0) && (cnt_q < act_f_q);
  assign a_on   = out_q & ~dead_r;
  assign b_on   = ~out_q & ~dead_f;

  always_comb begin
    case (mode_type'(main_q[2:0]))
      mode_async_steer: raw = {out_q, out_q, out_q, out_q};
      mode_sync_steer:  raw = {out_q, out_q, out_q, out_q};
      mode_full_fwd:    raw = {out_q & ~dead_f, 1'b0, 1'b0, 1'b1};
      mode_full_rev:    raw = {1'b0, 1'b1, out_q & ~dead_r, 1'b0};
      mode_half_bridge: raw = {b_on, a_on, b_on, a_on};
      mode_push_pull:   raw = {~out_q, out_q, ~out_q, out_q};
      default:          raw = 4'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-output steering, polarity and override
  outputs_type drive_d, drive_q;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      logic [1:0] lvl;
      logic       wave;
      assign lvl  = (g % 2 == 1) ? hf_q[level_bd_lsb +: 2] : hf_q[level_ac_lsb +: 2];
      assign wave = (main_q[2:1] == 2'b00) ? (str_q[g] ? raw[g] : str_q[g+4])
                                           : raw[g];
      always_comb begin
        drive_d.float_n[g] = 1'b0;
        if (run_q) drive_d.level[g] = wave ^ pol_q[g];
        else begin
          case (lvl)
            lvl_high:  drive_d.level[g] = 1'b1;
            lvl_low:   drive_d.level[g] = 1'b0;
            lvl_float: begin
              drive_d.level[g]   = 1'b0;
              drive_d.float_n[g] = 1'b1;
            end
            default:   drive_d.level[g] = pol_q[g];
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_q <= reset_zero; pol_q <= reset_zero; clk_q <= reset_zero;
      dat_q <= reset_zero; str_q <= reset_zero; hf_q <= reset_halt_first;
      hs_q <= reset_zero; dbr_q <= reset_zero; dbf_q <= reset_zero;
      act_r_q <= 6'h0; act_f_q <= 6'h0; seen_fall_q <= 1'b0;
      ack_q <= 1'b0; rdat_q <= 32'h0;
      sync1_q <= 1'b0; sync2_q <= 1'b0; prev_q <= 1'b0;
      run_q <= 1'b0; out_q <= 1'b0; cnt_q <= 6'h0;
      drive_q <= '0;
    end else if (clk_en) begin
      main_q <= main_d; pol_q <= pol_d; clk_q <= clk_d; dat_q <= dat_d;
      str_q <= str_d; hf_q <= hf_d; hs_q <= hs_d; dbr_q <= dbr_d; dbf_q <= dbf_d;
      act_r_q <= act_r_d; act_f_q <= act_f_d; seen_fall_q <= seen_fall_d;
      ack_q <= ack_d; rdat_q <= rdat_d;
      sync1_q <= sel_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      run_q <= run_d; out_q <= out_d; cnt_q <= cnt_d;
      drive_q <= drive_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  assign drive = drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_load_needs_enable;
    @(posedge ref_clk) disable iff (sys_rst)
    main_q[load_bit] |-> main_q[enable_bit];
  endproperty
  a_load_needs_enable: assert property (p_load_needs_enable) else $error("load without enable");

  property p_disabled_idle;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !main_q[enable_bit]) |=> (cnt_q == 6'h0 && !run_q);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("counter busy while disabled");

  property p_resume_on_rise;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !run_q && $past(run_q)==1'b0 && run_d) |-> rise;
  endproperty
  a_resume_on_rise: assert property (p_resume_on_rise) else $error("resume without rising edge");

  property p_load_copies;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && en && main_q[load_bit] && rise && seen_fall_q)
      |=> (!main_q[load_bit] && act_r_q == $past(dbr_q[5:0]));
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("buffer load missed");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    ((main_q & ~mask_control_main) == 8'h0) && ((pol_q & ~mask_polarity) == 8'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_sync_delay;
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en ##1 clk_en |=> sync2_q == $past(sel_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync chain broken");

  property p_halt_force;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && halt_now) |=> hf_q[halt_flag_bit];
  endproperty
  a_halt_force: assert property (p_halt_force) else $error("halt not flagged");

  property p_override_high;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !run_q && hf_q[level_ac_lsb +: 2] == lvl_high) |=> drive_q.level[0];
  endproperty
  a_override_high: assert property (p_override_high) else $error("override level wrong");

  property p_override_float;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !run_q && hf_q[level_bd_lsb +: 2] == lvl_float)
      |=> (drive_q.float_n[1] && drive_q.float_n[3]);
  endproperty
  a_override_float: assert property (p_override_float) else $error("override float missing");

  // Between input edges a running unit counts one step per tick
  property p_count_advance;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && en && !hf_q[halt_flag_bit] && run_q && !rise && !fall
      && tick && cnt_q != 6'h3f) |=> cnt_q == $past(cnt_q) + 6'h1;
  endproperty
  a_count_advance: assert property (p_count_advance) else $error("dead-band count stalled");

  property p_tick_gates_count;
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && en && !hf_q[halt_flag_bit] && run_q && clk_q[0] && !fast_osc_tick
      && !rise && !fall) |=> $stable(cnt_q);
  endproperty
  a_tick_gates_count: assert property (p_tick_gates_count) else $error("count moved without tick");

  c_load:    cover property (@(posedge ref_clk) main_q[load_bit] ##[1:200] !main_q[load_bit]);
  c_run:     cover property (@(posedge ref_clk) !run_q ##1 run_q);
  c_halt:    cover property (@(posedge ref_clk) run_q ##1 !run_q);
  c_deadband: cover property (@(posedge ref_clk) run_q && out_q && dead_r ##1 a_on);
  c_restart: cover property (@(posedge ref_clk)
    hf_q[halt_flag_bit] && hf_q[restart_bit] ##1 !hf_q[halt_flag_bit]);

endmodule // wave_ctrl
`default_nettype wire

// ### pkg/wave_ctrl_pkg.sv
// Package: register map, field positions, modes and carriers of the waveform control block
package wave_ctrl_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [3:0] off_control_main   = 4'h0;
  localparam logic [3:0] off_polarity       = 4'h4;
  localparam logic [3:0] off_clock_select   = 4'h8;
  localparam logic [3:0] off_data_select    = 4'hc;
  localparam logic [4:0] off_steering       = 5'h10;
  localparam logic [4:0] off_halt_first     = 5'h14;
  localparam logic [4:0] off_halt_sources   = 5'h18;
  localparam logic [4:0] off_rise_count     = 5'h1c;
  localparam logic [5:0] off_fall_count     = 6'h20;

  // Field positions
  localparam int enable_bit       = 7;
  localparam int load_bit         = 6;
  localparam int input_level_bit  = 5;
  localparam int halt_flag_bit    = 7;
  localparam int restart_bit      = 6;
  localparam int level_bd_lsb     = 4;
  localparam int level_ac_lsb     = 2;

  // Writable masks (unimplemented bits read zero)
  localparam logic [7:0] mask_control_main = 8'hc7;
  localparam logic [7:0] mask_polarity     = 8'h0f;
  localparam logic [7:0] mask_clock_select = 8'h01;
  localparam logic [7:0] mask_data_select  = 8'h0f;
  localparam logic [7:0] mask_halt_first   = 8'hfc;
  localparam logic [7:0] mask_halt_sources = 8'h1f;
  localparam logic [7:0] mask_deadband     = 8'h3f;

  // Reset values
  localparam logic [7:0] reset_zero        = 8'h00;
  localparam logic [7:0] reset_halt_first  = 8'h94;

  // Override level codes
  localparam logic [1:0] lvl_inactive = 2'h0;
  localparam logic [1:0] lvl_float    = 2'h1;
  localparam logic [1:0] lvl_low      = 2'h2;
  localparam logic [1:0] lvl_high     = 2'h3;

  typedef enum logic [2:0] {
    mode_async_steer = 3'b000,
    mode_sync_steer  = 3'b001,
    mode_full_fwd    = 3'b010,
    mode_full_rev    = 3'b011,
    mode_half_bridge = 3'b100,
    mode_push_pull   = 3'b101
  } mode_type;

  localparam int source_count = 14;

  // Output group carrier
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] float_n;
  } outputs_type;

endpackage

// ### sim/switch_driver_model.sv
// Behavioural model of the external switch drivers fed by the four outputs
`timescale 1ns/1ps
`default_nettype none
module switch_driver_model
  import wave_ctrl_pkg::*;
(
  // Outputs of the block
  input  wire wave_ctrl_pkg::outputs_type drive,
  // Gate levels seen by the switches
  output logic [3:0]                      gate
);
  import wave_ctrl_pkg::*;
  // A floated pin is held off by the external pull-down
  assign gate = drive.level & ~drive.float_n;
endmodule // switch_driver_model
`default_nettype wire

// ### sim/wave_ctrl_tb.sv
// Self-checking testbench of the waveform control block over Wishbone
`timescale 1ns/1ps
`default_nettype none
module wave_ctrl_tb;
  import wave_ctrl_pkg::*;
  localparam logic [5:0] a_main = 6'(off_control_main);
  localparam logic [5:0] a_pol  = 6'(off_polarity);
  localparam logic [5:0] a_dat  = 6'(off_data_select);
  localparam logic [5:0] a_str  = 6'(off_steering);
  localparam logic [5:0] a_halt = 6'(off_halt_first);
  localparam logic [5:0] a_src  = 6'(off_halt_sources);
  logic        ref_clk, sys_rst, clk_en, fast_osc_tick, cyc_i, stb_i, we_i;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ack_o;
  logic [13:0] source_in;
  logic [4:0]  halt_in_n;
  logic [3:0]  gate;
  outputs_type drive;
  int          n_mismatch, check_count;
  logic [5:0]  ua [6] = '{a_pol, 6'(off_clock_select), a_dat, a_src, 6'(off_rise_count),
                          6'(off_fall_count)};
  logic [7:0]  um [6] = '{mask_polarity, mask_clock_select, mask_data_select,
                          mask_halt_sources, mask_deadband, mask_deadband};
  always #12.5 ref_clk = ~ref_clk;
  wave_ctrl wave_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .fast_osc_tick(fast_osc_tick), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .source_in(source_in),
    .halt_in_n(halt_in_n), .drive(drive));
  switch_driver_model switch_driver_model_i (.drive(drive), .gate(gate));
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      fail("no ack");
      final_report;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    check_count++;
    if ((q & m) !== (e & m)) fail($sformatf("read %h got %h exp %h", a, q, e));
  endtask
  task automatic wait_drive(input logic [3:0] lv, input logic [3:0] fl);
    int n;
    n = 0;
    @(negedge ref_clk);
    while ((drive.level !== lv || drive.float_n !== fl) && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check_count++;
    if (n >= 40) begin
      fail($sformatf("drive %h/%h exp %h/%h", drive.level, drive.float_n, lv, fl));
      final_report;
    end
  endtask
  task automatic src(input logic [13:0] v);
    @(posedge ref_clk);
    source_in <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  // Moves the source and counts sampled all-low cycles until the level lv shows
  task automatic dead_len(input logic [13:0] v, input logic [3:0] lv, input int want);
    int n, z;
    @(posedge ref_clk);
    source_in <= v;
    n = 0;
    z = 0;
    @(negedge ref_clk);
    while (drive.level !== lv && n < 40) begin
      if (drive.level === 4'h0) z++;
      @(negedge ref_clk);
      n++;
    end
    check_count++;
    if (n >= 40 || z != want) fail($sformatf("dead band %0d exp %0d", z, want));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; sys_rst = 1'b1; clk_en = 1'b1; fast_osc_tick = 1'b1; cyc_i = 1'b0;
    stb_i = 1'b0; we_i = 1'b0; adr_i = 6'h00; sel_i = 4'hf; dat_i = 32'h0;
    source_in = 14'h0000; halt_in_n = 5'h1f; n_mismatch = 0; check_count = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(a_main, reset_zero, 8'hff);
    rd(a_pol, reset_zero, 8'hdf);
    rd(6'(off_clock_select), reset_zero, 8'hff);
    rd(a_dat, reset_zero, 8'hff);
    rd(a_halt, reset_halt_first, 8'hff);
    for (int i = 0; i < 6; i++) begin
      wr(ua[i], 8'hff);
      rd(ua[i], um[i], i == 0 ? 8'hdf : 8'hff);
      wr(ua[i], 8'h00);
    end
    wr(6'h24, 8'hff);
    rd(6'h24, 8'h00, 8'hff);
    for (int m = 0; m < 8; m++) begin
      wr(a_main, 8'(m));
      rd(a_main, 8'(m), 8'hff);
    end
    // Enable and load in one write: load refused
    wr(a_main, 8'hff);
    rd(a_main, 8'h87, 8'hff);
    wr(a_main, 8'hc7);
    src(14'h0001);
    rd(a_main, 8'hc7, 8'hff);
    src(14'h0000);
    src(14'h0001);
    rd(a_main, 8'h87, 8'hff);
    wr(a_main, 8'h00);
    for (int k = 0; k < 14; k++) begin
      wr(a_dat, 8'(k));
      src(14'h0001 << k);
      rd(a_pol, 8'h20, 8'h20);
      src(~(14'h0001 << k));
      rd(a_pol, 8'h00, 8'h20);
    end
    wr(a_dat, 8'h00);
    src(14'h0000);
    // Override levels while disabled
    wr(a_halt, 8'hac);
    wait_drive(4'h5, 4'h0);
    wr(a_halt, 8'h94);
    wait_drive(4'h0, 4'hf);
    wr(a_halt, 8'h80);
    wait_drive(4'h0, 4'h0);
    wr(a_pol, 8'h0f);
    wait_drive(4'hf, 4'h0);
    wr(a_pol, 8'h00);
    // Steering run after software clears the halt flag
    wr(a_str, 8'h0f);
    wr(a_halt, 8'hac);
    wr(a_main, 8'h80);
    wait_drive(4'h5, 4'h0);
    wr(a_halt, 8'h2c);
    rd(a_halt, 8'h2c, 8'hff);
    wait_drive(4'h5, 4'h0);
    src(14'h0001);
    wait_drive(4'hf, 4'h0);
    wr(a_main, 8'h00);
    wr(a_pol, 8'h05);
    wr(a_main, 8'h80);
    src(14'h0000);
    src(14'h0001);
    wait_drive(4'ha, 4'h0);
    src(14'h0000);
    wait_drive(4'h5, 4'h0);
    wr(a_main, 8'h00);
    wr(a_pol, 8'h00);
    // External halt, then automatic restart
    wr(a_src, 8'h01);
    halt_in_n <= 5'h1e;
    rd(a_halt, 8'h80, 8'h80);
    wait_drive(4'h5, 4'h0);
    wr(a_halt, 8'h6c);
    rd(a_halt, 8'h80, 8'h80);
    wr(a_main, 8'h80);
    halt_in_n <= 5'h1f;
    repeat (8) @(posedge ref_clk);
    rd(a_halt, 8'h6c, 8'hff);
    src(14'h0001);
    wait_drive(4'hf, 4'h0);
    wr(a_main, 8'h00);
    wait_drive(4'h5, 4'h0);
    // Half-bridge dead bands counted on the system clock
    wr(6'(off_rise_count), 8'h05);
    wr(6'(off_fall_count), 8'h03);
    wr(a_main, 8'h04);
    wr(a_main, 8'h84);
    src(14'h0000);
    src(14'h0001);
    wait_drive(4'h5, 4'h0);
    dead_len(14'h0000, 4'ha, 3);
    dead_len(14'h0001, 4'h5, 5);
    // Fast clock selected without ticks: the dead band holds
    wr(a_main, 8'h04);
    wr(6'(off_clock_select), 8'h01);
    fast_osc_tick <= 1'b0;
    wr(a_main, 8'h84);
    src(14'h0000);
    src(14'h0001);
    repeat (20) @(negedge ref_clk);
    check_count++;
    if (drive.level !== 4'h0) fail("dead band ran without tick");
    @(posedge ref_clk);
    fast_osc_tick <= 1'b1;
    wait_drive(4'h5, 4'h0);
    wr(a_main, 8'h04);
    wait_drive(4'h5, 4'h0);
    final_report;
  end
endmodule // wave_ctrl_tb
`default_nettype wire
